// *** core/rrm_pkg.sv ***
// Constants shared by the reset and reset-mode control block.
// Assumes a single 25 MHz core clock and a 32-bit AHB-Lite register bus.
package rrm_pkg;

  // Register byte addresses on the AHB-Lite bus.
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_LASTCMD = 8'h08;
  localparam logic [7:0] ADDR_CMD     = 8'h0C;

  // Control register fields and reset value.
  localparam int          CTRL_AFC_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

  // Status byte field positions.
  localparam int ST_RESET_BIT  = 0;
  localparam int ST_POR_BIT    = 1;
  localparam int ST_NORMAL_BIT = 2;
  localparam int ST_GLITCH_BIT = 3;
  localparam int ST_AFC_LSB    = 4;
  localparam int AFC_W         = 4;

  // Serial command words.
  localparam logic [15:0] CMD_SW_RESET    = 16'hFE00;
  localparam logic [7:0]  CMD_FIFO_MODE_HI = 8'hC8;
  localparam int          CMD_MODE_BIT    = 0;
  localparam logic [4:0]  SPI_WORD_BITS   = 5'h10;

  // Reset event timing.
  localparam int CLK_MHZ          = 25;
  localparam int POR_TIME_US      = 100000;
  localparam int SW_RESET_TIME_US = 250;
  localparam int POR_CYCLES       = POR_TIME_US * CLK_MHZ;
  localparam int SWRST_CYCLES     = SW_RESET_TIME_US * CLK_MHZ;
  localparam int CNT_W            = 22;

  // Reset sequencer states.
  typedef enum logic [1:0] {
    RRM_ST_POR,
    RRM_ST_SWRST,
    RRM_ST_RUN
  } rrm_state_e;

endpackage

// *** core/rrm_reset_ctrl.sv ***
// Reset sequencer and reset-mode control with an AHB-Lite register slave.
// Assumes a 25 MHz core_clk, synchronous serial pins and a single AHB master.
`timescale 1ns/1ps
module rrm_reset_ctrl
  import rrm_pkg::*;
#(
  parameter int POR_CYC   = POR_CYCLES,
  parameter int SWRST_CYC = SWRST_CYCLES
)(
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  // AHB-Lite slave.
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic [31:0]           hrdata,
  output logic                  hresp,
  // Serial command pins.
  input  wire logic             sck,
  input  wire logic             sdi,
  input  wire logic             chip_select_low,
  output logic                  sdo,
  // Analog and receiver status.
  input  wire logic             supply_glitch,
  input  wire logic [AFC_W-1:0] afc_offset,
  input  wire logic             fifo_irq_req,
  // Control outputs.
  output logic                  host_interrupt_low,
  output logic                  chip_reset_active,
  output logic                  glitch_detect_en,
  output logic                  afc_enable
);

  localparam logic [CNT_W-1:0] POR_LOAD   = CNT_W'(POR_CYC - 1);
  localparam logic [CNT_W-1:0] SWRST_LOAD = CNT_W'(SWRST_CYC - 1);

  rrm_state_e       state_ff;
  rrm_state_e       nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             normal_ff;
  logic             nxt_normal;
  logic [31:0]      ctrl_ff;
  logic [15:0]      lastcmd_ff;
  logic             reset_active_ff;
  logic             glitch_en_ff;
  logic             hirq_low_ff;
  logic             wr_pend_ff;
  logic [7:0]       wr_addr_ff;
  logic [31:0]      hrdata_ff;
  logic [15:0]      spi_word;
  logic             spi_valid;
  logic             sdo_ff;

  // Sequencer view.
  wire running   = (state_ff == RRM_ST_RUN);
  wire in_reset  = ~running;

  // Bus address phase and data-phase write strobes.
  wire        take_ap = hsel & htrans[1] & hready;
  wire [7:0]  ap_addr = haddr[7:0];
  wire        wr_ctrl = wr_pend_ff & (wr_addr_ff == ADDR_CTRL);
  wire        wr_cmd  = wr_pend_ff & (wr_addr_ff == ADDR_CMD);

  // Commands from the pins win over a same-cycle command written by software.
  wire        cmd_valid = running & (spi_valid | wr_cmd);
  wire [15:0] cmd_word  = spi_valid ? spi_word : hwdata[15:0];

  // Command decode.
  wire mode_cmd    = cmd_valid & (cmd_word[15:8] == CMD_FIFO_MODE_HI);
  wire sw_reset_go = cmd_valid & (cmd_word == CMD_SW_RESET) & ~normal_ff;
  wire glitch_go   = running & supply_glitch & ~normal_ff;

  // Status byte as seen over the bus and on the serial output.
  wire [7:0] status_byte;
  assign status_byte[ST_RESET_BIT]  = reset_active_ff;
  assign status_byte[ST_POR_BIT]    = (state_ff == RRM_ST_POR);
  assign status_byte[ST_NORMAL_BIT] = normal_ff;
  assign status_byte[ST_GLITCH_BIT] = glitch_en_ff;
  assign status_byte[ST_AFC_LSB +: AFC_W] = afc_offset;

  // Read mux for the address phase; unmapped addresses read as zero.
  wire [31:0] rd_mux = (ap_addr == ADDR_CTRL)    ? ctrl_ff :
                       (ap_addr == ADDR_STATUS)  ? {24'h00_0000, status_byte} :
                       (ap_addr == ADDR_LASTCMD) ? {16'h0000, lastcmd_ff} :
                       32'h0000_0000;

  // The serial shifter is held clear for the whole reset event.
  rrm_spi_cmd u_spi (
    .core_clk        (core_clk),
    .reset_n         (reset_n),
    .clear           (in_reset),
    .sck             (sck),
    .sdi             (sdi),
    .chip_select_low (chip_select_low),
    .sdo_ff          (sdo_ff),
    .status_word     ({status_byte, 8'h00}),
    .word_ff         (spi_word),
    .word_valid_ff   (spi_valid)
  );

  // Next state of the sequencer; a glitch while running in sensitive mode restarts the long power-on event.
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      RRM_ST_POR, RRM_ST_SWRST: begin
        if (cnt_ff == '0) begin
          nxt_state = RRM_ST_RUN;
        end else begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end
      end
      RRM_ST_RUN: begin
        if (glitch_go) begin
          nxt_state = RRM_ST_POR;
          nxt_cnt   = POR_LOAD;
        end else if (sw_reset_go) begin
          nxt_state = RRM_ST_SWRST;
          nxt_cnt   = SWRST_LOAD;
        end
      end
      default: begin
        nxt_state = RRM_ST_POR;
        nxt_cnt   = POR_LOAD;
      end
    endcase
  end

  // Sequencer registers; power-up starts a full-length event.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= RRM_ST_POR;
      cnt_ff   <= POR_LOAD;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Reset mode: any reset event forces sensitive mode back.
  assign nxt_normal = in_reset ? 1'b0 :
                      mode_cmd ? cmd_word[CMD_MODE_BIT] : normal_ff;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      normal_ff <= 1'b0;
    end else begin
      normal_ff <= nxt_normal;
    end
  end

  // Software-visible registers are reinitialised by every reset event.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff    <= CTRL_RESET;
      lastcmd_ff <= 16'h0000;
    end else if (in_reset) begin
      ctrl_ff    <= CTRL_RESET;
      lastcmd_ff <= 16'h0000;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= hwdata;
      end
      if (cmd_valid) begin
        lastcmd_ff <= cmd_word;
      end
    end
  end

  // Registered outputs; the interrupt is masked one cycle late and can stay asserted in the first cycle of a reset event.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_active_ff <= 1'b1;
      glitch_en_ff    <= 1'b1;
      hirq_low_ff     <= 1'b1;
    end else begin
      reset_active_ff <= (nxt_state != RRM_ST_RUN);
      glitch_en_ff    <= ~nxt_normal;
      hirq_low_ff     <= ~(fifo_irq_req & running);
    end
  end

  // Bus slave: zero wait states, writes land in the data phase.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff  <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= take_ap & hwrite;
      wr_addr_ff <= ap_addr;
      if (take_ap && !hwrite) begin
        hrdata_ff <= rd_mux;
      end
    end
  end

  assign hreadyout          = 1'b1;
  assign hresp              = 1'b0;
  assign hrdata             = hrdata_ff;
  assign sdo                = sdo_ff;
  assign host_interrupt_low = hirq_low_ff;
  assign chip_reset_active  = reset_active_ff;
  assign glitch_detect_en   = glitch_en_ff;
  assign afc_enable         = ctrl_ff[CTRL_AFC_EN_BIT];

  // No mode change or software reset is acted on during a reset event.
  property p_cmd_block;
    @(posedge core_clk) disable iff (!reset_n)
      in_reset |-> (!mode_cmd && !sw_reset_go && !cmd_valid) ##1 !spi_valid;
  endproperty
  a_cmd_block: assert property (p_cmd_block)
    else $error("Command acted on during reset.");

  // Leaving any reset event, the mode is sensitive.
  property p_leave_sensitive;
    @(posedge core_clk) disable iff (!reset_n)
      in_reset ##1 running |-> !normal_ff && glitch_detect_en;
  endproperty
  a_leave_sensitive: assert property (p_leave_sensitive)
    else $error("Reset did not end in sensitive mode.");

  // In normal mode glitches are ignored and detection is reported off.
  property p_glitch_off;
    @(posedge core_clk) disable iff (!reset_n)
      (normal_ff && running && supply_glitch) |=> state_ff == RRM_ST_RUN && !glitch_detect_en;
  endproperty
  a_glitch_off: assert property (p_glitch_off)
    else $error("Glitch caused reset in normal mode.");

  // Mode bit written by command shows as normal on the next cycle.
  property p_mode_set;
    @(posedge core_clk) disable iff (!reset_n)
      (mode_cmd && cmd_word[CMD_MODE_BIT]) |=> normal_ff ##1 !glitch_detect_en;
  endproperty
  a_mode_set: assert property (p_mode_set)
    else $error("Mode command did not select normal mode.");

  // Software reset in sensitive mode loads the short event.
  property p_swrst_start;
    @(posedge core_clk) disable iff (!reset_n)
      (running && cmd_valid && cmd_word == CMD_SW_RESET && !normal_ff && !supply_glitch)
        |=> state_ff == RRM_ST_SWRST && cnt_ff == SWRST_LOAD ##1 chip_reset_active;
  endproperty
  a_swrst_start: assert property (p_swrst_start)
    else $error("Software reset did not start.");

  // Software reset in normal mode starts no reset event; the word is still latched as the last command.
  property p_swrst_ignored;
    @(posedge core_clk) disable iff (!reset_n)
      (running && normal_ff && cmd_valid && cmd_word == CMD_SW_RESET)
        |=> running [*2];
  endproperty
  a_swrst_ignored: assert property (p_swrst_ignored)
    else $error("Software reset honoured in normal mode.");

  // From the second cycle of any event the registers hold their initial values.
  property p_reinit;
    @(posedge core_clk) disable iff (!reset_n)
      in_reset |=> ctrl_ff == CTRL_RESET && lastcmd_ff == 16'h0000 && !normal_ff;
  endproperty
  a_reinit: assert property (p_reinit)
    else $error("Registers not reinitialised by reset.");

  // The short event ends exactly when its count runs out.
  property p_swrst_end;
    @(posedge core_clk) disable iff (!reset_n)
      (state_ff == RRM_ST_SWRST && cnt_ff == '0) |=> running ##1 !chip_reset_active;
  endproperty
  a_swrst_end: assert property (p_swrst_end)
    else $error("Software reset length wrong.");

  // A status read returns the AFC offset sampled in its address phase.
  property p_afc_status;
    @(posedge core_clk) disable iff (!reset_n)
      (take_ap && !hwrite && ap_addr == ADDR_STATUS)
        |=> hrdata[ST_AFC_LSB +: AFC_W] == $past(afc_offset);
  endproperty
  a_afc_status: assert property (p_afc_status)
    else $error("Status read lost the AFC offset.");

  // A reset event reports sensitive mode on the status output unless a normal-mode command arrives in the cycle of the glitch that starts it.
  property p_sens_back;
    @(posedge core_clk) disable iff (!reset_n)
      $rose(chip_reset_active) |-> glitch_detect_en;
  endproperty
  a_sens_back: assert property (p_sens_back)
    else $error("Sensitive mode not restored at reset.");

endmodule // rrm_reset_ctrl

// *** core/rrm_spi_cmd.sv ***
// Serial command shifter: collects 16-bit words framed by chip select.
// Assumes sck, sdi and chip select are already synchronous to core_clk.
`timescale 1ns/1ps
module rrm_spi_cmd
  import rrm_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        clear,
  // Serial pins.
  input  wire logic        sck,
  input  wire logic        sdi,
  input  wire logic        chip_select_low,
  output logic             sdo_ff,
  // Word side.
  input  wire logic [15:0] status_word,
  output logic [15:0]      word_ff,
  output logic             word_valid_ff
);

  logic        sck_q_ff;
  logic        cs_q_ff;
  logic [4:0]  cnt_ff;
  logic [15:0] shift_ff;
  logic [15:0] stat_sh_ff;
  wire         cs_fall  = cs_q_ff & ~chip_select_low;
  wire         cs_rise  = ~cs_q_ff & chip_select_low;
  wire         sck_rise = ~sck_q_ff & sck & ~chip_select_low;
  wire         cnt_full = (cnt_ff > SPI_WORD_BITS);
  wire [4:0]   nxt_cnt  = cnt_full ? cnt_ff : cnt_ff + 5'h01;
  // Only an exact word closed by chip select counts; partial frames are dropped.
  wire         word_done = cs_rise & (cnt_ff == SPI_WORD_BITS) & ~clear;

  // Edge history of the serial pins.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_q_ff <= 1'b0;
      cs_q_ff  <= 1'b1;
    end else begin
      sck_q_ff <= sck;
      cs_q_ff  <= chip_select_low;
    end
  end

  // Bit counter and input shifter; a clear holds the shifter empty.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff   <= 5'h00;
      shift_ff <= 16'h0000;
    end else if (clear || cs_fall) begin
      cnt_ff   <= 5'h00;
      shift_ff <= 16'h0000;
    end else if (sck_rise) begin
      cnt_ff   <= nxt_cnt;
      shift_ff <= {shift_ff[14:0], sdi};
    end
  end

  // Status shifter, loaded when the frame opens, MSB first.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_sh_ff <= 16'h0000;
      sdo_ff     <= 1'b0;
    end else begin
      if (cs_fall) begin
        stat_sh_ff <= status_word;
      end else if (sck_rise) begin
        stat_sh_ff <= {stat_sh_ff[14:0], 1'b0};
      end
      sdo_ff <= stat_sh_ff[15];
    end
  end

  // Word hand-off, one-cycle strobe.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      word_ff       <= 16'h0000;
      word_valid_ff <= 1'b0;
    end else begin
      word_valid_ff <= word_done;
      if (word_done) begin
        word_ff <= shift_ff;
      end
    end
  end

  // A word strobe follows a frame with exactly sixteen clocks.
  property p_whole_word;
    @(posedge core_clk) disable iff (!reset_n)
      word_valid_ff |-> $past(cnt_ff) == SPI_WORD_BITS && $past(chip_select_low);
  endproperty
  a_whole_word: assert property (p_whole_word)
    else $error("Command word taken from a partial frame.");

endmodule // rrm_spi_cmd

// *** tb/rrm_host_model.sv ***
// Behavioural model of the external microcontroller on the serial command link.
// Assumes the bench calls its tasks and that the device samples sdi on each sck rise.
`timescale 1ns/1ps
module rrm_host_model (
  // Clock.
  input  wire logic core_clk,
  // Device outputs.
  input  wire logic sdo,
  input  wire logic host_interrupt_low,
  // Serial pins driven by the host.
  output logic      sck,
  output logic      sdi,
  output logic      chip_select_low
);
  logic [15:0] rx_word;

  // Serial clock stands low outside frames, select stays released.
  initial begin
    sck             = 1'b0;
    sdi             = 1'b1;
    chip_select_low = 1'b1;
    rx_word         = 16'h0000;
  end

  // Sends the first nbits of a word MSB first; fewer than 16 makes a broken frame.
  task automatic send_word(input logic [15:0] w, input int nbits);
    @(posedge core_clk) chip_select_low <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      @(posedge core_clk) sdi <= w[15-i];
      @(posedge core_clk) sck <= 1'b1;
      // Status bits are taken at the falling serial clock, once the shift has settled.
      @(posedge core_clk) sck <= 1'b0;
      rx_word <= {rx_word[14:0], sdo};
    end
    // A released data line does not keep its last level.
    @(posedge core_clk) chip_select_low <= 1'b1;
    sdi <= ~w[16-nbits];
    repeat (2) @(posedge core_clk);
  endtask

  // Data are read only once the interrupt request has gone low.
  task automatic wait_irq(output logic seen);
    seen = 1'b0;
    for (int i = 0; i < 200 && !seen; i++) begin
      @(posedge core_clk);
      seen = (host_interrupt_low === 1'b0);
    end
  endtask
endmodule // rrm_host_model

// *** tb/tb_radio_reset_mode_control.sv ***
// Self-checking bench for the reset and reset-mode control block.
// Assumes the block's register map and serial timing; reset counts are shortened.
`timescale 1ns/1ps
module tb_radio_reset_mode_control;
  import rrm_pkg::*;
  localparam int POR_T = 200;
  localparam int SWR_T = 10;
  logic             core_clk, reset_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]      haddr, hwdata, hrdata, rdat;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic             sck, sdi, chip_select_low, sdo, supply_glitch, fifo_irq_req;
  logic [AFC_W-1:0] afc_offset;
  logic             host_interrupt_low, chip_reset_active, glitch_detect_en, afc_enable, ok;
  int               n_fail, compares, n;

  // The single slave's ready is the bus ready.
  assign hready = hreadyout;

  rrm_reset_ctrl #(.POR_CYC(POR_T), .SWRST_CYC(SWR_T)) i_dut (
    .core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sck(sck), .sdi(sdi),
    .chip_select_low(chip_select_low), .sdo(sdo), .supply_glitch(supply_glitch),
    .afc_offset(afc_offset), .fifo_irq_req(fifo_irq_req),
    .host_interrupt_low(host_interrupt_low), .chip_reset_active(chip_reset_active),
    .glitch_detect_en(glitch_detect_en), .afc_enable(afc_enable));

  rrm_host_model i_host (
    .core_clk(core_clk), .sdo(sdo), .host_interrupt_low(host_interrupt_low),
    .sck(sck), .sdi(sdi), .chip_select_low(chip_select_low));

  // 25 MHz core clock.
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Waits for an edge with hready high; a hang ends the run.
  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge core_clk);
    while (hready !== 1'b1) begin
      if (++k > 100) begin
        n_fail++;
        give_verdict();
      end
      @(posedge core_clk);
    end
  endtask

  // One single word transfer: address phase, then data phase.
  task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rdat = hrdata;
    check(hresp, 0);
  endtask

  task automatic ahb_wr(input logic [31:0] a, input logic [31:0] d);
    ahb_xfer(1'b1, a, d);
    // Let the data-phase edge settle so the written value is visible on return.
    @(posedge core_clk);
  endtask

  task automatic ahb_rd(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] m);
    ahb_xfer(1'b0, a, 32'h0000_0000);
    check(rdat & m, exp);
  endtask

  // Counts cycles until the reset event is over.
  task automatic wait_low(output int cnt);
    cnt = 0;
    while (chip_reset_active !== 1'b0) begin
      @(posedge core_clk);
      if (++cnt > 1000) begin
        n_fail++;
        give_verdict();
      end
    end
  endtask

  task automatic pulse_glitch();
    supply_glitch <= 1'b1;
    repeat (3) @(posedge core_clk);
    supply_glitch <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  // Main sequence.
  initial begin
    reset_n = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = 32'h0000_0000; supply_glitch = 1'b0; afc_offset = 4'hA;
    fifo_irq_req = 1'b0; n_fail = 0; compares = 0;
    repeat (2) @(posedge core_clk);
    check(glitch_detect_en, 1);
    check(host_interrupt_low, 1);
    reset_n <= 1'b1;
    // Commands sent while power-on reset runs must be dropped.
    i_host.send_word(16'hC801, 16);
    ahb_wr(ADDR_CMD, 32'h0000_C801);
    ahb_wr(ADDR_CTRL, 32'h0000_0001);
    check(chip_reset_active, 1);
    wait_low(n);
    check(glitch_detect_en, 1);
    ahb_rd(ADDR_CTRL, CTRL_RESET, 32'hFFFF_FFFF);
    ahb_rd(ADDR_LASTCMD, 32'h0000_0000, 32'hFFFF_FFFF);
    ahb_rd(32'h0000_0010, 32'h0000_0000, 32'hFFFF_FFFF);
    ahb_wr(ADDR_CTRL, 32'h0000_0001);
    check(afc_enable, 1);
    ahb_rd(ADDR_CTRL, 32'h0000_0001, 32'hFFFF_FFFF);
    // The offset is read with the control loop stopped.
    ahb_wr(ADDR_CTRL, 32'h0000_0000);
    ahb_rd(ADDR_STATUS, 32'h0000_00A8, 32'hFFFF_FFFD);
    check(host_interrupt_low, 1);
    fifo_irq_req <= 1'b1;
    i_host.wait_irq(ok);
    check(ok, 1);
    check(host_interrupt_low, 0);
    // The host empties the receive buffer after the packet; the request then drops.
    fifo_irq_req <= 1'b0;
    repeat (2) @(posedge core_clk);
    check(host_interrupt_low, 1);
    // Serial mode command selects normal mode; glitches and soft reset are then ignored.
    i_host.send_word(16'hC801, 16);
    check(i_host.rx_word, 32'h0000_A800);
    repeat (3) @(posedge core_clk);
    check(glitch_detect_en, 0);
    ahb_rd(ADDR_STATUS, 32'h0000_00A4, 32'hFFFF_FFFD);
    ahb_rd(ADDR_LASTCMD, 32'h0000_C801, 32'hFFFF_FFFF);
    pulse_glitch();
    check(chip_reset_active, 0);
    i_host.send_word(CMD_SW_RESET, 16);
    repeat (4) @(posedge core_clk);
    check(chip_reset_active, 0);
    // Back to sensitive through the register path, then a broken frame.
    ahb_wr(ADDR_CMD, 32'h0000_C800);
    repeat (3) @(posedge core_clk);
    check(glitch_detect_en, 1);
    ahb_wr(ADDR_CTRL, 32'h0000_0001);
    i_host.send_word(CMD_SW_RESET, 15);
    repeat (4) @(posedge core_clk);
    check(chip_reset_active, 0);
    // A whole soft reset word starts a short reset that clears the registers.
    i_host.send_word(CMD_SW_RESET, 16);
    @(posedge core_clk);
    check(chip_reset_active, 1);
    wait_low(n);
    check(n >= SWR_T - 4 && n <= SWR_T + 1, 1);
    check(afc_enable, 0);
    ahb_rd(ADDR_CTRL, CTRL_RESET, 32'hFFFF_FFFF);
    ahb_rd(ADDR_LASTCMD, 32'h0000_0000, 32'hFFFF_FFFF);
    // Normal mode is lost again on a power-on reset of full length.
    ahb_wr(ADDR_CMD, 32'h0000_C801);
    repeat (3) @(posedge core_clk);
    check(glitch_detect_en, 0);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    check(glitch_detect_en, 1);
    wait_low(n);
    check(n >= POR_T - 2 && n <= POR_T + 2, 1);
    // In sensitive mode a supply glitch does start a reset.
    pulse_glitch();
    check(chip_reset_active, 1);
    wait_low(n);
    give_verdict();
  end
endmodule // tb_radio_reset_mode_control
